// *** include/dtc_pkg.sv ***
// Summary of operation
// - Two independent 16-bit timer/event counters
// - Mode 0: 8-bit count, 5-bit prescaler
// - Mode 1: both bytes cascade, no prescaler
// - Mode 2: low byte reloads from high
// - Split mode: timer 0 low byte normal
// - Split high byte: internal clock, timer 1 bits
// - Timer 1 raises no overflow in split
// - Timer 1 mode 3 freezes its count
// - Gating bit requires pin high plus run
// - Source bit picks clock or count pin
// - Run bits enable counting, timer 1 bit 6
// - Overflow sets flag, service clears it
// - Trigger type: falling edge or low level
// - Mode field zero selects 13-bit prescaled count
`default_nettype none
package dtc_pkg;
	// Register byte offsets
	localparam int DTC_AW = 8;
	localparam logic [7:0] DTC_OFS_MODE = 8'h00;
	localparam logic [7:0] DTC_OFS_CTRL = 8'h04;
	localparam logic [7:0] DTC_OFS_T0L = 8'h08;
	localparam logic [7:0] DTC_OFS_T0H = 8'h0c;
	localparam logic [7:0] DTC_OFS_T1L = 8'h10;
	localparam logic [7:0] DTC_OFS_T1H = 8'h14;
	localparam logic [7:0] DTC_OFS_ISTAT = 8'h18;
	localparam logic [7:0] DTC_OFS_IEN = 8'h1c;
	localparam logic [7:0] DTC_OFS_ICLR = 8'h20;
	// Run and flag register bit positions
	localparam int DTC_TF1 = 7;
	localparam int DTC_TR1 = 6;
	localparam int DTC_TF0 = 5;
	localparam int DTC_TR0 = 4;
	localparam int DTC_IE1 = 3;
	localparam int DTC_IT1 = 2;
	localparam int DTC_IE0 = 1;
	localparam int DTC_IT0 = 0;
	// Mode nibble layout: timer 1 at 7:4, timer 0 at 3:0
	localparam int DTC_NIB_T1 = 4;
	localparam int DTC_NIB_GATE = 3;
	localparam int DTC_NIB_SRC = 2;
	// Interrupt status bit positions
	localparam int DTC_ST_TF0 = 0;
	localparam int DTC_ST_IE0 = 1;
	localparam int DTC_ST_TF1 = 2;
	localparam int DTC_ST_IE1 = 3;
	localparam int DTC_NEV = 4;
	// Reset values
	localparam logic [7:0] DTC_RST_BYTE = 8'h00;
	localparam logic [31:0] DTC_RST_WORD = 32'h00000000;
	localparam logic [4:0] DTC_PRE_TOP = 5'h1f;
	localparam logic [7:0] DTC_BYTE_TOP = 8'hff;
	// Operating modes
	typedef enum logic [1:0]
	{
		DTC_M13 = 2'h0,
		DTC_M16 = 2'h1,
		DTC_M8R = 2'h2,
		DTC_MSPLIT = 2'h3
	} dtc_mode_type;
endpackage : dtc_pkg
`default_nettype wire

// *** rtl/dtc_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtc_edge #(
	parameter int W = 2
)(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Synchronised level and trigger type
	input wire logic [W-1:0] lvl,
	input wire logic [W-1:0] edge_mode,
	// Detected events
	output logic [W-1:0] fall,
	output logic [W-1:0] trig
);
	import dtc_pkg::*;
	logic [W-1:0] prev_q;

	////////////////////////////////////////////////////////////////
	// Previous level, starts high so reset gives no false edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev_q <= '1;
		else
			prev_q <= lvl;
	end

	// Falling edge, or a low level when edge mode is off
	assign fall = prev_q & ~lvl;
	assign trig = (edge_mode & fall) | (~edge_mode & ~lvl);
endmodule : dtc_edge
`default_nettype wire

// *** rtl/dtc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtc_sync #(
	parameter int W = 2
)(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pin side
	input wire logic [W-1:0] pin,
	// Synchronised level
	output logic [W-1:0] sync
);
	import dtc_pkg::*;
	logic [W-1:0] meta_q;

	////////////////////////////////////////////////////////////////
	// Two flip-flop synchroniser; resets to the pins' idle high level
	// so that reset shows neither a false falling edge nor a low level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_q <= '1;
			sync <= '1;
		end
		else
		begin
			meta_q <= pin;
			sync <= meta_q;
		end
	end
endmodule : dtc_sync
`default_nettype wire

// *** rtl/dtc_top.sv ***
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module dtc_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// External count pins, one per timer
	input wire logic [1:0] count_pin,
	// External interrupt pins, also timer gates
	input wire logic [1:0] ext_irq_pin,
	// Interrupt request
	output logic irq
);
	import dtc_pkg::*;

	////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] timer_mode_select_q;
	logic [7:0] timer_run_and_flags_q;
	logic [7:0] timer_run_and_flags_d;
	logic [7:0] timer0_low_byte_q;
	logic [7:0] timer0_high_byte_q;
	logic [7:0] timer1_low_byte_q;
	logic [7:0] timer1_high_byte_q;
	logic [DTC_NEV-1:0] istat_q;
	logic [DTC_NEV-1:0] istat_d;
	logic [DTC_NEV-1:0] ien_q;
	logic [DTC_NEV-1:0] iclr;
	logic [DTC_NEV-1:0] ev;
	logic wr_q;
	logic [DTC_AW-1:0] waddr_q;
	logic [7:0] wdat;
	logic aph;
	logic [31:0] rd_d;
	logic [1:0] cnt_s;
	logic [1:0] ext_s;
	logic [1:0] cnt_fall;
	logic [1:0] ext_trig;
	logic [1:0] edge_mode;
	logic [3:0] nib0;
	logic [3:0] nib1;
	dtc_mode_type mode0;
	dtc_mode_type mode1;
	logic split;
	logic run0;
	logic run1;
	logic inc0;
	logic inc1;
	logic th0_inc;
	logic ov_th0;
	logic ov0;
	logic ov1;
	logic set_tf0;
	logic set_tf1;
	logic [16:0] s0;
	logic [16:0] s1;

	////////////////////////////////////////////////////////////////
	// One count step of a timer: returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(
		input dtc_mode_type m,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			DTC_M13:
			begin
				r[4:0] = lo[4:0] + 5'h01;
				if (lo[4:0] == DTC_PRE_TOP)
					r[16:8] = {1'b0, hi} + 9'h001;
			end
			DTC_M16:
				r = {1'b0, hi, lo} + 17'h00001;
			DTC_M8R:
			begin
				r[16:0] = {1'b0, hi, lo};
				{r[16], r[7:0]} = {1'b0, lo} + 9'h001;
				if (r[16])
					r[7:0] = hi;
			end
			default:
				{r[16], r[7:0]} = {1'b0, lo} + 9'h001;
		endcase
		return r;
	endfunction : dtc_step

	////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detectors
	dtc_sync #(.W(2)) u_cnt_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(count_pin),
		.sync(cnt_s)
	);

	dtc_sync #(.W(2)) u_ext_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(ext_irq_pin),
		.sync(ext_s)
	);

	dtc_edge #(.W(2)) u_cnt_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.lvl(cnt_s),
		.edge_mode(2'h3),
		.fall(cnt_fall),
		.trig()
	);

	dtc_edge #(.W(2)) u_ext_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.lvl(ext_s),
		.edge_mode(edge_mode),
		.fall(),
		.trig(ext_trig)
	);

	////////////////////////////////////////////////////////////////
	// AHB-Lite address phase and zero-wait data phase
	assign aph = hsel & htrans[1] & hready;
	assign wdat = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q <= 1'b0;
			waddr_q <= '0;
		end
		else
		begin
			wr_q <= aph & hwrite;
			waddr_q <= haddr[DTC_AW-1:0];
		end
	end

	// Read mux; clear register and unmapped words read zero
	always_comb
	begin
		rd_d = DTC_RST_WORD;
		case (haddr[DTC_AW-1:0])
			DTC_OFS_MODE: rd_d[7:0] = timer_mode_select_q;
			DTC_OFS_CTRL: rd_d[7:0] = timer_run_and_flags_q;
			DTC_OFS_T0L: rd_d[7:0] = timer0_low_byte_q;
			DTC_OFS_T0H: rd_d[7:0] = timer0_high_byte_q;
			DTC_OFS_T1L: rd_d[7:0] = timer1_low_byte_q;
			DTC_OFS_T1H: rd_d[7:0] = timer1_high_byte_q;
			DTC_OFS_ISTAT: rd_d[DTC_NEV-1:0] = istat_q;
			DTC_OFS_IEN: rd_d[DTC_NEV-1:0] = ien_q;
			default: rd_d = DTC_RST_WORD;
		endcase
	end

	// Read data registered at the address phase edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= DTC_RST_WORD;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end
		else
		begin
			hrdata <= (aph & !hwrite) ? rd_d : DTC_RST_WORD;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_mode_select_q <= DTC_RST_BYTE;
		else if (wr_q && waddr_q == DTC_OFS_MODE)
			timer_mode_select_q <= wdat;
	end

	// Per-timer nibbles in the same order
	assign nib0 = timer_mode_select_q[DTC_NIB_T1-1:0];
	assign nib1 = timer_mode_select_q[7:DTC_NIB_T1];
	assign mode0 = dtc_mode_type'(nib0[1:0]);
	assign mode1 = dtc_mode_type'(nib1[1:0]);
	assign split = (mode0 == DTC_MSPLIT);
	assign edge_mode = {timer_run_and_flags_q[DTC_IT1], timer_run_and_flags_q[DTC_IT0]};

	////////////////////////////////////////////////////////////////
	// Count enables: run bit, optional gate, clock or pin source
	assign run0 = timer_run_and_flags_q[DTC_TR0]
		& (!nib0[DTC_NIB_GATE] | ext_s[0]);
	// In split mode timer 1 has lost its run bit and runs unless its gate pin holds it
	assign run1 = (timer_run_and_flags_q[DTC_TR1] | split)
		& (!nib1[DTC_NIB_GATE] | ext_s[1]);
	assign inc0 = run0 & (nib0[DTC_NIB_SRC] ? cnt_fall[0] : 1'b1);
	assign inc1 = run1 & (nib1[DTC_NIB_SRC] ? cnt_fall[1] : 1'b1)
		& (mode1 != DTC_MSPLIT);
	// Split high byte: internal clock only, run by timer 1's run bit
	assign th0_inc = split & timer_run_and_flags_q[DTC_TR1];

	assign s0 = dtc_step(mode0, timer0_high_byte_q, timer0_low_byte_q);
	assign s1 = dtc_step(mode1, timer1_high_byte_q, timer1_low_byte_q);
	assign ov0 = inc0 & s0[16];
	assign ov1 = inc1 & s1[16];
	assign ov_th0 = th0_inc & (timer0_high_byte_q == DTC_BYTE_TOP);
	assign set_tf0 = ov0;
	assign set_tf1 = split ? ov_th0 : ov1;

	////////////////////////////////////////////////////////////////
	// Timer 0 bytes; a software write wins over the count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer0_low_byte_q <= DTC_RST_BYTE;
		else if (wr_q && waddr_q == DTC_OFS_T0L)
			timer0_low_byte_q <= wdat;
		else if (inc0)
			timer0_low_byte_q <= s0[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer0_high_byte_q <= DTC_RST_BYTE;
		else if (wr_q && waddr_q == DTC_OFS_T0H)
			timer0_high_byte_q <= wdat;
		else if (split)
		begin
			if (th0_inc)
				timer0_high_byte_q <= timer0_high_byte_q + 8'h01;
		end
		else if (inc0)
			timer0_high_byte_q <= s0[15:8];
	end

	// Timer 1 bytes; frozen in its mode 3
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer1_low_byte_q <= DTC_RST_BYTE;
		else if (wr_q && waddr_q == DTC_OFS_T1L)
			timer1_low_byte_q <= wdat;
		else if (inc1)
			timer1_low_byte_q <= s1[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer1_high_byte_q <= DTC_RST_BYTE;
		else if (wr_q && waddr_q == DTC_OFS_T1H)
			timer1_high_byte_q <= wdat;
		else if (inc1)
			timer1_high_byte_q <= s1[15:8];
	end

	////////////////////////////////////////////////////////////////
	// Run and flag register: write, then service clear, then set
	assign iclr = (wr_q && waddr_q == DTC_OFS_ICLR) ? wdat[DTC_NEV-1:0] : '0;

	always_comb
	begin
		timer_run_and_flags_d = timer_run_and_flags_q;
		if (wr_q && waddr_q == DTC_OFS_CTRL)
			timer_run_and_flags_d = wdat;
		if (iclr[DTC_ST_TF0])
			timer_run_and_flags_d[DTC_TF0] = 1'b0;
		if (iclr[DTC_ST_TF1])
			timer_run_and_flags_d[DTC_TF1] = 1'b0;
		if (iclr[DTC_ST_IE0])
			timer_run_and_flags_d[DTC_IE0] = 1'b0;
		if (iclr[DTC_ST_IE1])
			timer_run_and_flags_d[DTC_IE1] = 1'b0;
		if (set_tf0)
			timer_run_and_flags_d[DTC_TF0] = 1'b1;
		if (set_tf1)
			timer_run_and_flags_d[DTC_TF1] = 1'b1;
		if (ext_trig[0])
			timer_run_and_flags_d[DTC_IE0] = 1'b1;
		if (ext_trig[1])
			timer_run_and_flags_d[DTC_IE1] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_run_and_flags_q <= DTC_RST_BYTE;
		else
			timer_run_and_flags_q <= timer_run_and_flags_d;
	end

	////////////////////////////////////////////////////////////////
	// Sticky interrupt status, enable, level output
	assign ev[DTC_ST_TF0] = set_tf0;
	assign ev[DTC_ST_IE0] = ext_trig[0];
	assign ev[DTC_ST_TF1] = set_tf1;
	assign ev[DTC_ST_IE1] = ext_trig[1];
	assign istat_d = (istat_q & ~iclr) | ev;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			istat_q <= '0;
		else
			istat_q <= istat_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ien_q <= '0;
		else if (wr_q && waddr_q == DTC_OFS_IEN)
			ien_q <= wdat[DTC_NEV-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(istat_q & ien_q);
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking dtc_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	mode_write_a: assert property (
		wr_q && waddr_q == DTC_OFS_MODE |=> timer_mode_select_q == $past(wdat))
		else $error("mode register did not take written value");

	prescale_step_a: assert property (
		inc0 && mode0 == DTC_M13 && !wr_q && timer0_low_byte_q[4:0] != DTC_PRE_TOP
		|=> timer0_high_byte_q == $past(timer0_high_byte_q)
		&& timer0_low_byte_q[4:0] == 5'($past(timer0_low_byte_q[4:0]) + 5'h01))
		else $error("prescaled count step wrong");

	prescale_carry_a: assert property (
		inc0 && mode0 == DTC_M13 && !wr_q && timer0_low_byte_q[4:0] == DTC_PRE_TOP
		|=> timer0_low_byte_q[4:0] == 5'h00
		&& timer0_high_byte_q == 8'($past(timer0_high_byte_q) + 8'h01))
		else $error("prescaler carry into high byte wrong");

	cascade_carry_a: assert property (
		inc0 && mode0 == DTC_M16 && !wr_q && timer0_low_byte_q == DTC_BYTE_TOP
		|=> timer0_high_byte_q == 8'($past(timer0_high_byte_q) + 8'h01))
		else $error("16-bit cascade carry wrong");

	reload_low_a: assert property (
		inc1 && mode1 == DTC_M8R && !wr_q && timer1_low_byte_q == DTC_BYTE_TOP
		|=> timer1_low_byte_q == $past(timer1_high_byte_q)
		&& ($past(split) || timer_run_and_flags_q[DTC_TF1]))
		else $error("auto reload wrong");

	split_low_ovf_a: assert property (
		split && inc0 && timer0_low_byte_q == DTC_BYTE_TOP
		|=> timer_run_and_flags_q[DTC_TF0] ##1 1'b1)
		else $error("split low byte overflow lost");

	split_high_ovf_a: assert property (
		split && ov_th0 |=> timer_run_and_flags_q[DTC_TF1] && istat_q[DTC_ST_TF1])
		else $error("split high byte overflow lost");

	split_t1_quiet_a: assert property (
		split && ov1 && !ov_th0 && !timer_run_and_flags_q[DTC_TF1] && !wr_q
		|=> !timer_run_and_flags_q[DTC_TF1])
		else $error("timer 1 raised overflow in split mode");

	t1_freeze_a: assert property (
		mode1 == DTC_MSPLIT && !wr_q
		|=> $stable(timer1_low_byte_q) && $stable(timer1_high_byte_q))
		else $error("timer 1 counted in mode 3");

	gate_hold_a: assert property (
		nib0[DTC_NIB_GATE] && !ext_s[0] && !wr_q |=> $stable(timer0_low_byte_q))
		else $error("gated timer 0 counted with pin low");

	run_off_a: assert property (
		!timer_run_and_flags_q[DTC_TR1] |-> !th0_inc && (split || !inc1))
		else $error("timer 1 counted with run bit clear");

	clock_src_a: assert property (
		run0 && !nib0[DTC_NIB_SRC] |-> inc0)
		else $error("internal source did not count");

	level_trig_a: assert property (
		!timer_run_and_flags_q[DTC_IT1] && !ext_s[1] |=> timer_run_and_flags_q[DTC_IE1])
		else $error("low level did not set edge flag");

	service_clear_a: assert property (
		iclr[DTC_ST_TF0] && !set_tf0 |=> !timer_run_and_flags_q[DTC_TF0] && !istat_q[DTC_ST_TF0])
		else $error("service did not clear overflow flag");

	set_wins_a: assert property (
		iclr[DTC_ST_IE0] && ext_trig[0]
		|=> timer_run_and_flags_q[DTC_IE0] && istat_q[DTC_ST_IE0])
		else $error("edge event lost against clear");

	irq_level_a: assert property (
		|(istat_q & ien_q) |=> irq)
		else $error("interrupt output missing");

	split_ovf_c: cover property (split && ov_th0 ##1 irq);
	reload_c: cover property (inc1 && mode1 == DTC_M8R && s1[16]);
	edge_trig_c: cover property (timer_run_and_flags_q[DTC_IT0] && ext_trig[0]);
	gate_c: cover property (nib0[DTC_NIB_GATE] && ext_s[0] && inc0);
endmodule : dtc_top
`default_nettype wire

// *** sim/dtc_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
	// Clock
	input wire logic hclk,
	// Pins toward the block
	output logic [1:0] count_pin,
	output logic [1:0] ext_irq_pin
);
	// Pins idle high, so nothing counts and no trigger fires
	initial
	begin
		count_pin = 2'h3;
		ext_irq_pin = 2'h3;
	end
	// Falling edges on one count pin, low held three cycles, high held four between pulses
	task pulse(input int idx, input int n);
		for (int k = 0; k < n; k++)
		begin
			@(posedge hclk);
			count_pin[idx] <= 1'b0;
			repeat (3) @(posedge hclk);
			count_pin[idx] <= 1'b1;
			repeat (3) @(posedge hclk);
		end
	endtask : pulse
	// Interrupt pin level, also the gate of its timer
	task set_irq(input int idx, input logic v);
		@(posedge hclk);
		ext_irq_pin[idx] <= v;
		repeat (3) @(posedge hclk);
	endtask : set_irq
endmodule : dtc_pin_model
`default_nettype wire

// *** sim/test_dual_timer_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_dual_timer_counter;
	import dtc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [1:0] count_pin;
	logic [1:0] ext_irq_pin;
	logic irq;
	logic [31:0] rv;
	int n_fail = 0;
	int n_checks = 0;

	// Clock of 100 ns
	always #50 hclk = ~hclk;

	dtc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .count_pin(count_pin), .ext_irq_pin(ext_irq_pin), .irq(irq));
	dtc_pin_model u_pins (.hclk(hclk), .count_pin(count_pin), .ext_irq_pin(ext_irq_pin));

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task end_sim;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	// Compare one value
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Next edge with ready high, bounded
	task wait_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && i < 20)
		begin
			@(posedge hclk);
			i++;
		end
		if (hreadyout !== 1'b1)
		begin
			n_fail++;
			end_sim;
		end
	endtask : wait_rdy
	// One single word transfer, address phase then data phase
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		wait_rdy;
		rv = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus
	// Register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	// Register read and compare
	task rc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rv, {24'h000000, e});
	endtask : rc
	// Wait for a level on the interrupt line, bounded
	task wait_irq(input logic v);
		for (int i = 0; i < 400 && irq !== v; i++)
			@(posedge hclk);
		if (irq !== v)
		begin
			n_fail++;
			end_sim;
		end
	endtask : wait_irq

	////////////////////////////////////////////////////////////////////////
	// Reset values and an unmapped place
	task t_reset;
		rc(DTC_OFS_MODE, 8'h00);
		rc(DTC_OFS_CTRL, 8'h00);
		rc(DTC_OFS_IEN, 8'h00);
		rc(8'h24, 8'h00);
	endtask : t_reset
	// Cascaded overflow, flag, mask and service
	task t_cascade;
		wr(DTC_OFS_MODE, 8'h01);
		wr(DTC_OFS_T0H, 8'hff);
		wr(DTC_OFS_T0L, 8'hf0);
		wr(DTC_OFS_IEN, 8'h01);
		wr(DTC_OFS_CTRL, 8'h10);
		wait_irq(1'b1);
		rc(DTC_OFS_CTRL, 8'h30);
		rc(DTC_OFS_ISTAT, 8'h01);
		wr(DTC_OFS_IEN, 8'h00);
		rc(DTC_OFS_IEN, 8'h00);
		chk({31'h0, irq}, 32'h0);
		wr(DTC_OFS_IEN, 8'h01);
		rc(DTC_OFS_IEN, 8'h01);
		chk({31'h0, irq}, 32'h1);
		wr(DTC_OFS_ICLR, 8'h01);
		rc(DTC_OFS_ISTAT, 8'h00);
		rc(DTC_OFS_CTRL, 8'h10);
		chk({31'h0, irq}, 32'h0);
		wr(DTC_OFS_CTRL, 8'h00);
	endtask : t_cascade
	// Auto-reload on timer 1 counting its pin
	task t_reload;
		wr(DTC_OFS_MODE, 8'h60);
		wr(DTC_OFS_T1L, 8'hfe);
		wr(DTC_OFS_T1H, 8'hf0);
		wr(DTC_OFS_CTRL, 8'h40);
		u_pins.pulse(1, 3);
		rc(DTC_OFS_T1L, 8'hf1);
		rc(DTC_OFS_CTRL, 8'hc0);
		wr(DTC_OFS_CTRL, 8'h00);
	endtask : t_reload
	// Prescaler carry into the high byte
	task t_presc;
		wr(DTC_OFS_MODE, 8'h04);
		wr(DTC_OFS_T0L, 8'h1f);
		wr(DTC_OFS_T0H, 8'h05);
		wr(DTC_OFS_CTRL, 8'h10);
		u_pins.pulse(0, 1);
		rc(DTC_OFS_T0L, 8'h00);
		rc(DTC_OFS_T0H, 8'h06);
		wr(DTC_OFS_CTRL, 8'h00);
	endtask : t_presc
	// Gate pin low blocks counting; low level sets the edge flag
	task t_gate;
		wr(DTC_OFS_MODE, 8'h0d);
		wr(DTC_OFS_T0L, 8'h00);
		wr(DTC_OFS_T0H, 8'h00);
		u_pins.set_irq(0, 1'b0);
		wr(DTC_OFS_CTRL, 8'h10);
		u_pins.pulse(0, 2);
		rc(DTC_OFS_T0L, 8'h00);
		u_pins.set_irq(0, 1'b1);
		u_pins.pulse(0, 2);
		rc(DTC_OFS_T0L, 8'h02);
		rc(DTC_OFS_CTRL, 8'h12);
		wr(DTC_OFS_CTRL, 8'h00);
	endtask : t_gate
	// Falling edge trigger and service of its flag
	task t_edge;
		wr(DTC_OFS_CTRL, 8'h04);
		u_pins.set_irq(1, 1'b0);
		u_pins.set_irq(1, 1'b1);
		rc(DTC_OFS_CTRL, 8'h0c);
		wr(DTC_OFS_ICLR, 8'h08);
		rc(DTC_OFS_CTRL, 8'h04);
		wr(DTC_OFS_CTRL, 8'h00);
	endtask : t_edge
	// Split mode: high byte of timer 0 uses timer 1 run and flag
	task t_split;
		wr(DTC_OFS_ICLR, 8'h0f);
		wr(DTC_OFS_T0H, 8'hf0);
		wr(DTC_OFS_T1H, 8'hff);
		wr(DTC_OFS_T1L, 8'hfa);
		wr(DTC_OFS_MODE, 8'h13);
		wr(DTC_OFS_IEN, 8'h04);
		wr(DTC_OFS_CTRL, 8'h40);
		repeat (4) @(posedge hclk);
		rc(DTC_OFS_CTRL, 8'h40);
		chk({31'h0, irq}, 32'h0);
		wait_irq(1'b1);
		rc(DTC_OFS_CTRL, 8'hc0);
		wr(DTC_OFS_CTRL, 8'h00);
		wr(DTC_OFS_ICLR, 8'h0f);
	endtask : t_split
	// Timer 1 mode 3 holds its count until another mode
	task t_freeze;
		wr(DTC_OFS_MODE, 8'h30);
		wr(DTC_OFS_T1L, 8'h10);
		wr(DTC_OFS_CTRL, 8'h40);
		repeat (5) @(posedge hclk);
		rc(DTC_OFS_T1L, 8'h10);
		wr(DTC_OFS_MODE, 8'h10);
		repeat (2) @(posedge hclk);
		rc(DTC_OFS_T1L, 8'h12);
		wr(DTC_OFS_CTRL, 8'h00);
	endtask : t_freeze

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset;
		t_cascade;
		t_reload;
		t_presc;
		t_gate;
		t_edge;
		t_split;
		t_freeze;
		end_sim;
	end
endmodule : test_dual_timer_counter
`default_nettype wire
